// [hw/dlog_cmd_unit.sv]
// Device end: memory and control command interpreter of the datalogger
`timescale 1ns/10ps
module dlog_cmd_unit
  import dlog_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYC_DFLT
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Link
  dlog_link_if.device      link,
  // Scratchpad state and storage
  input  wire logic [15:0] target_address,
  input  wire logic [4:0]  ending_offset,
  input  wire logic        partial_byte_flag,
  input  wire logic        sp_write,
  output logic      [4:0]  sp_addr,
  input  wire logic [7:0]  sp_rdata,
  output logic      [7:0]  ending_status,
  output logic             authorization_accepted_flag,
  // Memory port
  output logic      [15:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_we,
  output logic      [7:0]  mem_wdata,
  // Passwords
  input  wire logic        pw_enabled,
  input  wire logic [63:0] full_pw,
  input  wire logic [63:0] read_pw,
  // Mission control
  input  wire logic        start_on_temp_alarm,
  input  wire logic        start_delay_done,
  input  wire logic        temp_alarm,
  input  wire logic        sample_tick,
  input  wire logic        sample_active,
  input  wire logic        mission_stop,
  output logic             mission_active_flag,
  output logic             awaiting_temp_alarm_flag,
  output logic             memory_cleared_flag,
  output logic             sample_enable,
  output logic             log_first_sample,
  output logic             set_timestamp,
  output logic             clear_mission,
  // Forced conversion
  output logic             conv_start,
  input  wire logic [15:0] sensor_temp,
  input  wire logic [15:0] sensor_data,
  output logic      [15:0] latest_temp,
  output logic      [15:0] latest_serial
);

  typedef enum logic [9:0] {
    S_CMD       = 10'h001,
    S_PARAM     = 10'h002,
    S_PW        = 10'h004,
    S_DUMMY     = 10'h008,
    S_COPY      = 10'h010,
    S_COPY_DONE = 10'h020,
    S_RD_DATA   = 10'h040,
    S_RD_CRC    = 10'h080,
    S_ONES      = 10'h100,
    S_HALT      = 10'h200
  } cmd_state_t;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_DELAY = 5'h02,
    M_WAIT  = 5'h04,
    M_FIRST = 5'h08,
    M_LOG   = 5'h10
  } mission_state_t;

  typedef struct packed {
    cmd_state_t     state;
    mission_state_t mstate;
    logic [7:0]     cmd;
    logic [3:0]     cnt;
    logic [23:0]    auth;
    logic [63:0]    pw;
    logic [15:0]    addr;
    logic [15:0]    crc;
    logic [15:0]    tx;
    logic [3:0]     txl;
    logic           page_end;
    logic           last;
    logic           alt;
    logic           rd_bit;
    logic           rd_valid;
    logic           accepted;
    logic           wiped;
    logic [10:0]    tmr;
    logic           we;
    logic [7:0]     wdata;
    logic [23:0]    conv_cnt;
    logic [15:0]    ltemp;
    logic [15:0]    lserial;
    logic           clear_p;
    logic           conv_p;
    logic           first_p;
    logic           ts_p;
  } dev_state_t;

  dev_state_t q_ff;
  dev_state_t nxt_q;

  logic [7:0] es_byte;
  logic       blocked;

  // ==========================================================================
  // Status byte and outputs
  always_comb
  begin
    es_byte = {q_ff.accepted, 1'b0, partial_byte_flag, ending_offset};
  end

  assign ending_status               = es_byte;
  assign authorization_accepted_flag = q_ff.accepted;
  assign sp_addr                     = q_ff.addr[4:0];
  assign mem_addr                    = q_ff.addr;
  assign mem_we                      = q_ff.we;
  assign mem_wdata                   = q_ff.wdata;
  assign mission_active_flag         = (q_ff.mstate != M_IDLE);
  assign awaiting_temp_alarm_flag    = (q_ff.mstate == M_WAIT);
  assign memory_cleared_flag         = q_ff.wiped;
  assign sample_enable               = (q_ff.mstate == M_LOG);
  assign log_first_sample            = q_ff.first_p;
  assign set_timestamp               = q_ff.ts_p;
  assign clear_mission               = q_ff.clear_p;
  assign conv_start                  = q_ff.conv_p;
  assign latest_temp                 = q_ff.ltemp;
  assign latest_serial               = q_ff.lserial;
  assign link.rd_valid               = q_ff.rd_valid;
  assign link.rd_bit                 = q_ff.rd_bit;

  // Sampling or a running conversion owns the memory
  assign blocked = (q_ff.conv_cnt != 24'h00_0000) || sample_active;

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [7:0]  b;
    logic [7:0]  d;
    logic [15:0] crc_base;
    logic [15:0] v;
    logic        ok_full;
    logic        ok_read;
    logic        load;
    b        = link.wr_byte;
    d        = 8'h00;
    crc_base = q_ff.crc;
    v        = ~q_ff.crc;
    ok_full  = 1'b0;
    ok_read  = 1'b0;
    load     = 1'b0;
    nxt_q    = q_ff;
    nxt_q.rd_valid = 1'b0;
    nxt_q.we       = 1'b0;
    nxt_q.clear_p  = 1'b0;
    nxt_q.conv_p   = 1'b0;
    nxt_q.first_p  = 1'b0;
    nxt_q.ts_p     = 1'b0;

    if (sp_write)
      nxt_q.accepted = 1'b0;

    // Conversion runs on its own, unaffected by bus resets
    if (q_ff.conv_cnt != 24'h00_0000)
    begin
      nxt_q.conv_cnt = q_ff.conv_cnt - 24'h00_0001;
      if (q_ff.conv_cnt == 24'h00_0001)
      begin
        nxt_q.ltemp   = sensor_temp;
        nxt_q.lserial = sensor_data;
      end
    end

    unique case (q_ff.mstate)
      M_IDLE:  ;
      M_DELAY:
        if (start_delay_done)
          nxt_q.mstate = start_on_temp_alarm ? M_WAIT : M_LOG;
      M_WAIT:
        if (temp_alarm)
        begin
          nxt_q.first_p = 1'b1;
          nxt_q.mstate  = M_FIRST;
        end
      M_FIRST:
        if (sample_tick)
        begin
          nxt_q.ts_p   = 1'b1;
          nxt_q.mstate = M_LOG;
        end
      M_LOG:   ;
    endcase
    if (mission_stop)
      nxt_q.mstate = M_IDLE;

    // Incoming bytes
    if (link.wr_valid)
    begin
      unique case (q_ff.state)
        S_CMD:
        begin
          nxt_q.cmd = b;
          nxt_q.cnt = 4'h0;
          nxt_q.crc = crc16_byte(16'h0000, b);
          unique case (b)
            CMD_COPY, CMD_READ:   nxt_q.state = S_PARAM;
            CMD_CLEAR, CMD_START: nxt_q.state = S_PW;
            CMD_CONV:             nxt_q.state = S_DUMMY;
            default:              nxt_q.state = S_HALT;
          endcase
        end
        S_PARAM:
        begin
          nxt_q.auth = {b, q_ff.auth[23:8]};
          nxt_q.addr = {b, q_ff.addr[15:8]};
          nxt_q.crc  = crc16_byte(q_ff.crc, b);
          nxt_q.cnt  = q_ff.cnt + 4'h1;
          if (q_ff.cnt == ((q_ff.cmd == CMD_COPY) ? 4'h2 : 4'h1))
          begin
            nxt_q.state = S_PW;
            nxt_q.cnt   = 4'h0;
          end
        end
        S_PW:
        begin
          nxt_q.pw  = {b, q_ff.pw[63:8]};
          nxt_q.cnt = q_ff.cnt + 4'h1;
          ok_full   = !pw_enabled || (nxt_q.pw == full_pw);
          ok_read   = ok_full || (nxt_q.pw == read_pw);
          if (q_ff.cnt == 4'h7)
          begin
            if (q_ff.cmd == CMD_COPY)
            begin
              if (ok_full && (q_ff.auth == {es_byte, target_address}) && !blocked &&
                  !(mission_active_flag && in_range(target_address, REG_FIRST, REG_LAST)))
              begin
                nxt_q.accepted = 1'b1;
                nxt_q.addr     = target_address;
                nxt_q.tmr      = COPY_CYC - 11'h001;
                nxt_q.state    = S_COPY;
              end
              else
                nxt_q.state = S_HALT;
            end
            else if (q_ff.cmd == CMD_READ)
            begin
              nxt_q.state    = ok_read ? S_RD_DATA : S_HALT;
              nxt_q.txl      = 4'h0;
              nxt_q.page_end = 1'b0;
            end
            else
              nxt_q.state = S_DUMMY;
          end
        end
        S_DUMMY:
        begin
          nxt_q.state = S_HALT;
          ok_full     = !pw_enabled || (q_ff.pw == full_pw);
          if ((b == DUMMY_BYTE) && !mission_active_flag && !blocked)
          begin
            if ((q_ff.cmd == CMD_CLEAR) && ok_full)
            begin
              nxt_q.clear_p = 1'b1;
              nxt_q.wiped   = 1'b1;
            end
            else if ((q_ff.cmd == CMD_START) && ok_full && q_ff.wiped)
            begin
              nxt_q.mstate = M_DELAY;
              nxt_q.wiped  = 1'b0;
            end
            else if (q_ff.cmd == CMD_CONV)
            begin
              nxt_q.conv_cnt = 24'(CONV_CYC);
              nxt_q.conv_p   = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // Copy engine: one byte per timer period
    if (q_ff.state == S_COPY)
    begin
      nxt_q.tmr = q_ff.tmr - 11'h001;
      if (q_ff.tmr == 11'h001)
      begin
        nxt_q.wdata = sp_rdata;
        nxt_q.we    = 1'b1;
      end
      if (q_ff.tmr == 11'h000)
      begin
        if (q_ff.addr[4:0] == ending_offset)
        begin
          nxt_q.state = S_COPY_DONE;
          nxt_q.alt   = 1'b1;
        end
        else
        begin
          nxt_q.addr = q_ff.addr + 16'h0001;
          nxt_q.tmr  = COPY_CYC - 11'h001;
        end
      end
    end

    // Read slots
    if (link.rd_req)
    begin
      nxt_q.rd_valid = 1'b1;
      nxt_q.rd_bit   = 1'b1;
      if (((q_ff.state == S_RD_DATA) || (q_ff.state == S_RD_CRC)) && (q_ff.txl != 4'h0))
      begin
        nxt_q.rd_bit = q_ff.tx[0];
        nxt_q.tx     = {1'b0, q_ff.tx[15:1]};
        nxt_q.txl    = q_ff.txl - 4'h1;
      end
      else
      begin
        unique case (q_ff.state)
          S_COPY:      nxt_q.rd_bit = 1'b0;
          S_COPY_DONE:
          begin
            nxt_q.rd_bit = q_ff.alt;
            nxt_q.alt    = ~q_ff.alt;
          end
          S_RD_DATA:
            if (q_ff.page_end)
            begin
              nxt_q.rd_bit   = v[0];
              nxt_q.tx       = {1'b0, v[15:1]};
              nxt_q.txl      = 4'hF;
              nxt_q.page_end = 1'b0;
              nxt_q.state    = S_RD_CRC;
            end
            else
              load = 1'b1;
          S_RD_CRC:
          begin
            crc_base  = 16'h0000;
            nxt_q.crc = 16'h0000;
            if (q_ff.last)
              nxt_q.state = S_ONES;
            else
            begin
              nxt_q.state = S_RD_DATA;
              load        = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (load)
      begin
        if (blocked || in_range(q_ff.addr, RSV_FIRST, RSV_LAST) || (q_ff.addr > MEM_LAST_ADDR))
          d = FILL_BYTE;
        else if (in_range(q_ff.addr, PW_FIRST, PW_LAST))
          d = PW_BYTE;
        else
          d = mem_rdata;
        nxt_q.crc      = crc16_byte(crc_base, d);
        nxt_q.rd_bit   = d[0];
        nxt_q.tx       = {9'h000, d[7:1]};
        nxt_q.txl      = 4'h7;
        nxt_q.page_end = (q_ff.addr[4:0] == PAGE_END_OFF);
        nxt_q.last     = (q_ff.addr == MEM_LAST_ADDR);
        nxt_q.addr     = q_ff.addr + 16'h0001;
      end
    end

    if (link.rst_pulse && (q_ff.state != S_COPY))
    begin
      nxt_q.state    = S_CMD;
      nxt_q.cnt      = 4'h0;
      nxt_q.txl      = 4'h0;
      nxt_q.page_end = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_ff        <= '0;
      q_ff.state  <= S_CMD;
      q_ff.mstate <= M_IDLE;
      q_ff.rd_bit <= 1'b1;
    end
    else if (ce)
      q_ff <= nxt_q;
  end

endmodule : dlog_cmd_unit

// [hw/dlog_pkg.sv]
// Shared constants, codes and helper functions for the datalogger command unit
package dlog_pkg;

  // ==========================================================================
  // Command codes and fixed bytes
  localparam logic [7:0] CMD_COPY  = 8'h99;
  localparam logic [7:0] CMD_READ  = 8'h69;
  localparam logic [7:0] CMD_CLEAR = 8'h96;
  localparam logic [7:0] CMD_CONV  = 8'h55;
  localparam logic [7:0] CMD_START = 8'hCC;
  localparam logic [7:0] DUMMY_BYTE = 8'hFF;
  localparam logic [7:0] FILL_BYTE  = 8'hFF;
  localparam logic [7:0] PW_BYTE    = 8'h00;

  // ==========================================================================
  // Ending-status byte layout
  localparam int ES_ACCEPT_BIT  = 7;
  localparam int ES_ZERO_BIT    = 6;
  localparam int ES_PARTIAL_BIT = 5;
  localparam logic [4:0] PAGE_END_OFF = 5'h1F;
  localparam logic [5:0] SP_BYTES     = 6'h20;

  // ==========================================================================
  // Address map
  localparam logic [15:0] REG_FIRST     = 16'h0200;
  localparam logic [15:0] REG_LAST      = 16'h023F;
  localparam logic [15:0] PW_FIRST      = 16'h0220;
  localparam logic [15:0] PW_LAST       = 16'h022F;
  localparam logic [15:0] RSV_FIRST     = 16'h0280;
  localparam logic [15:0] RSV_LAST      = 16'h0FFF;
  localparam logic [15:0] MEM_LAST_ADDR = 16'h2FFF;

  // ==========================================================================
  // Timing
  localparam int CLK_NS   = 40;
  localparam int COPY_NS  = 2000;
  localparam logic [10:0] COPY_CYC = 11'((COPY_NS + CLK_NS - 1) / CLK_NS);
  localparam int CONV_MS  = 666;
  localparam int CONV_CYC_DFLT = (CONV_MS * 1000000) / CLK_NS;
  localparam logic [10:0] COPY_WAIT_CYC = 11'(COPY_CYC * SP_BYTES);

  // ==========================================================================
  // Functions
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (c[0] ^ d[i])
        c = (c >> 1) ^ 16'hA001;
      else
        c = c >> 1;
    end
    return c;
  endfunction : crc16_byte

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

endpackage : dlog_pkg

// [hw/dlog_link_if.sv]
// Byte and read-slot link between bus master and datalogger command unit
`timescale 1ns/10ps
interface dlog_link_if;
  logic       rst_pulse;
  logic       wr_valid;
  logic [7:0] wr_byte;
  logic       rd_req;
  logic       rd_valid;
  logic       rd_bit;

  modport device (input rst_pulse, input wr_valid, input wr_byte, input rd_req,
                  output rd_valid, output rd_bit);
  modport master (output rst_pulse, output wr_valid, output wr_byte, output rd_req,
                  input rd_valid, input rd_bit);
endinterface : dlog_link_if

// [hw/dlog_bus_master.sv]
// Master end: issues one memory or control command sequence per request
`timescale 1ns/10ps
module dlog_bus_master
  import dlog_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Link
  dlog_link_if.master      link,
  // Request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_cmd,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_es,
  input  wire logic [63:0] req_pw,
  input  wire logic [7:0]  req_rd_bytes,
  // Answer
  output logic             rx_valid,
  output logic      [7:0]  rx_byte,
  output logic             done
);

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_RST  = 5'h02,
    H_SEND = 5'h04,
    H_WAIT = 5'h08,
    H_READ = 5'h10
  } host_state_t;

  typedef struct packed {
    host_state_t state;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  es;
    logic [63:0] pw;
    logic [3:0]  idx;
    logic [7:0]  rdleft;
    logic [2:0]  bitn;
    logic [7:0]  rxsh;
    logic        pending;
    logic [10:0] wcnt;
    logic        rst_p;
    logic        wr_v;
    logic [7:0]  wr_b;
    logic        rd_r;
    logic        rx_v;
    logic [7:0]  rx_b;
    logic        done;
  } host_reg_t;

  host_reg_t q_ff;
  host_reg_t nxt_q;

  function automatic logic [3:0] param_cnt(input logic [7:0] c);
    return (c == CMD_COPY) ? 4'h3 : ((c == CMD_READ) ? 4'h2 : 4'h0);
  endfunction : param_cnt

  // Bytes sent after the command: parameters, password, then dummy
  function automatic logic [7:0] host_byte(input host_reg_t r);
    logic [3:0]  pc;
    logic [3:0]  k;
    logic [63:0] sh;
    pc = param_cnt(r.cmd);
    k  = r.idx - pc - 4'h1;
    sh = r.pw >> {k[2:0], 3'b000};
    if (r.idx == 4'h0)
      return r.cmd;
    else if (r.idx <= pc)
      return (r.idx == 4'h1) ? r.addr[7:0] : ((r.idx == 4'h2) ? r.addr[15:8] : r.es);
    else if ((r.cmd != CMD_CONV) && (r.idx <= pc + 4'h8))
      return sh[7:0];
    else
      return DUMMY_BYTE;
  endfunction : host_byte

  function automatic logic [3:0] last_idx(input logic [7:0] c);
    logic [3:0] n;
    n = param_cnt(c) + ((c == CMD_CONV) ? 4'h0 : 4'h8);
    if ((c == CMD_CLEAR) || (c == CMD_START) || (c == CMD_CONV))
      n = n + 4'h1;
    return n;
  endfunction : last_idx

  assign req_ready      = (q_ff.state == H_IDLE);
  assign rx_valid       = q_ff.rx_v;
  assign rx_byte        = q_ff.rx_b;
  assign done           = q_ff.done;
  assign link.rst_pulse = q_ff.rst_p;
  assign link.wr_valid  = q_ff.wr_v;
  assign link.wr_byte   = q_ff.wr_b;
  assign link.rd_req    = q_ff.rd_r;

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    nxt_q       = q_ff;
    nxt_q.rst_p = 1'b0;
    nxt_q.wr_v  = 1'b0;
    nxt_q.rd_r  = 1'b0;
    nxt_q.rx_v  = 1'b0;
    nxt_q.done  = 1'b0;
    unique case (q_ff.state)
      H_IDLE:
        if (req_valid)
        begin
          nxt_q.cmd    = req_cmd;
          nxt_q.addr   = req_addr;
          nxt_q.es     = req_es;
          nxt_q.pw     = req_pw;
          nxt_q.rdleft = req_rd_bytes;
          nxt_q.idx    = 4'h0;
          nxt_q.bitn   = 3'h0;
          nxt_q.rst_p  = 1'b1;
          nxt_q.state  = H_RST;
        end
      H_RST:
        nxt_q.state = H_SEND;
      H_SEND:
      begin
        nxt_q.wr_v = 1'b1;
        nxt_q.wr_b = host_byte(q_ff);
        nxt_q.idx  = q_ff.idx + 4'h1;
        if (q_ff.idx == last_idx(q_ff.cmd))
        begin
          nxt_q.state = (q_ff.cmd == CMD_COPY) ? H_WAIT : H_READ;
          nxt_q.wcnt  = COPY_WAIT_CYC;
        end
      end
      H_WAIT:
      begin
        nxt_q.wcnt = q_ff.wcnt - 11'h001;
        if (q_ff.wcnt == 11'h000)
          nxt_q.state = H_READ;
      end
      H_READ:
        if (q_ff.rdleft == 8'h00)
        begin
          nxt_q.done  = 1'b1;
          nxt_q.state = H_IDLE;
        end
        else if (!q_ff.pending)
        begin
          nxt_q.rd_r    = 1'b1;
          nxt_q.pending = 1'b1;
        end
        else if (link.rd_valid)
        begin
          nxt_q.pending = 1'b0;
          nxt_q.rxsh    = {link.rd_bit, q_ff.rxsh[7:1]};
          nxt_q.bitn    = q_ff.bitn + 3'h1;
          if (q_ff.bitn == 3'h7)
          begin
            nxt_q.rx_v   = 1'b1;
            nxt_q.rx_b   = {link.rd_bit, q_ff.rxsh[7:1]};
            nxt_q.rdleft = q_ff.rdleft - 8'h01;
          end
        end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_ff       <= '0;
      q_ff.state <= H_IDLE;
    end
    else if (ce)
      q_ff <= nxt_q;
  end

endmodule : dlog_bus_master

// [testbench/dlog_cmd_unit_asserts.sv]
// Link timing and status flag checks for the datalogger command unit
`timescale 1ns/10ps
module dlog_cmd_unit_asserts (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Link
  input wire logic       rd_req,
  input wire logic       rd_valid,
  input wire logic       rd_bit,
  // Device status
  input wire logic [7:0] ending_status,
  input wire logic       authorization_accepted_flag,
  input wire logic       sp_write,
  input wire logic       mem_we,
  input wire logic       clear_mission,
  input wire logic       memory_cleared_flag,
  input wire logic       mission_active_flag,
  input wire logic       conv_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Link answers
  property p_ans; rd_req |=> rd_valid; endproperty
  a_ans: assert property (p_ans) else $error("read slot not answered");
  property p_only; !rd_req |=> !rd_valid; endproperty
  a_only: assert property (p_only) else $error("answer without read slot");
  // Ones after the last page need the bit to hold
  property p_hold; !rd_valid |-> $stable(rd_bit); endproperty
  a_hold: assert property (p_hold) else $error("read bit moved between slots");
  // ==========================================================================
  // Status and command effects
  property p_es; ending_status[7:6] == {authorization_accepted_flag, 1'b0}; endproperty
  a_es: assert property (p_es) else $error("ending status layout wrong");
  property p_acc;
    authorization_accepted_flag && !sp_write |=> authorization_accepted_flag;
  endproperty
  a_acc: assert property (p_acc) else $error("accepted flag lost");
  property p_we; mem_we |=> !mem_we [*8]; endproperty
  a_we: assert property (p_we) else $error("copy bytes too close");
  property p_clr; clear_mission |-> ##[0:1] memory_cleared_flag; endproperty
  a_clr: assert property (p_clr) else $error("cleared flag not set");
  property p_clrm; clear_mission |-> !mission_active_flag; endproperty
  a_clrm: assert property (p_clrm) else $error("clear during mission");
  property p_conv; conv_start |-> !mission_active_flag; endproperty
  a_conv: assert property (p_conv) else $error("conversion during mission");
endmodule : dlog_cmd_unit_asserts

// [testbench/datalogger_memory_command_unit_tb.sv]
// Self-checking bench: master and device ends joined on one link
`timescale 1ns/10ps
module datalogger_memory_command_unit_tb import dlog_pkg::*;;
  logic        clk = 1'b0, arst_n = 1'b0, ce = 1'b1, req_valid = 1'b0, pw_enabled = 1'b0;
  logic        start_on_temp_alarm = 1'b1, req_ready, rx_valid, done, acc, mem_we, conv_start;
  logic        clear_mission, mission_active_flag, awaiting_temp_alarm_flag;
  logic        memory_cleared_flag, log_first_sample, set_timestamp, sample_enable;
  logic [4:0]  ending_offset = 5'h1F, pl = 5'h00, sp_addr;
  logic [7:0]  req_cmd = '0, req_es = '0, req_rd_bytes = '0, rx_byte, sp_rdata, mem_rdata;
  logic [7:0]  ending_status, rxq[$], exq[$];
  logic [15:0] req_addr = '0, target_address = 16'h0040, sensor_temp = 16'h0ABC;
  logic [15:0] mem_addr, latest_temp;
  logic [63:0] req_pw = '0, full_pw = 64'h0123_4567_89AB_CDEF, read_pw = 64'h5A5A_0F0F_3C3C_1234;
  int          miscompares = 0, total_checks = 0, cyc = 0, nwe = 0, nlog = 0, nts = 0;

  dlog_link_if u_dlog_link_if ();
  assign sp_rdata  = {3'b000, sp_addr} ^ 8'h5A;
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8];
  dlog_cmd_unit #(.CONV_CYC(20)) u_dlog_cmd_unit (
    .clk, .arst_n, .ce, .link(u_dlog_link_if), .target_address, .ending_offset,
    .partial_byte_flag(1'b0), .sp_write(pl[4]), .sp_addr, .sp_rdata, .ending_status,
    .authorization_accepted_flag(acc), .mem_addr, .mem_rdata, .mem_we, .mem_wdata(),
    .pw_enabled, .full_pw, .read_pw, .start_on_temp_alarm, .start_delay_done(pl[3]),
    .temp_alarm(pl[2]), .sample_tick(pl[1]), .sample_active(1'b0), .mission_stop(pl[0]),
    .mission_active_flag, .awaiting_temp_alarm_flag, .memory_cleared_flag, .sample_enable,
    .log_first_sample, .set_timestamp, .clear_mission, .conv_start, .sensor_temp,
    .sensor_data(~sensor_temp), .latest_temp, .latest_serial());
  dlog_bus_master u_dlog_bus_master (
    .clk, .arst_n, .ce, .link(u_dlog_link_if), .req_valid, .req_ready, .req_cmd, .req_addr,
    .req_es, .req_pw, .req_rd_bytes, .rx_valid, .rx_byte, .done);
  dlog_cmd_unit_asserts u_dlog_cmd_unit_asserts (
    .clk, .arst_n, .rd_req(u_dlog_link_if.rd_req), .rd_valid(u_dlog_link_if.rd_valid),
    .rd_bit(u_dlog_link_if.rd_bit), .ending_status, .authorization_accepted_flag(acc),
    .sp_write(pl[4]), .mem_we, .clear_mission, .memory_cleared_flag, .mission_active_flag,
    .conv_start);

  // ==========================================================================
  // Clock, capture and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (rx_valid)
      rxq.push_back(rx_byte);
    nwe += mem_we;
    nlog += log_first_sample;
    nts += set_timestamp;
    if (cyc == 30000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic pulse(input int i);
    pl[i] = 1'b1;
    @(negedge clk);
    pl[i] = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse

  // Falling edge to falling edge
  task automatic run(input logic [7:0] cm, input logic [15:0] a, input logic [7:0] es,
                     input logic [63:0] pw, input logic [7:0] n);
    int t;
    t = 0;
    rxq = {};
    {req_cmd, req_addr, req_es, req_pw, req_rd_bytes} = {cm, a, es, pw, n};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    do
    begin
      @(negedge clk);
      t++;
    end
    while (done !== 1'b1 && t < 3000);
    chk(done, 1'b1);
    @(negedge clk);
  endtask : run

  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction : crc

  function automatic logic [7:0] mv(input logic [15:0] a);
    if (a >= PW_FIRST && a <= PW_LAST)
      return PW_BYTE;
    if (a >= RSV_FIRST && a <= RSV_LAST)
      return FILL_BYTE;
    return a[7:0] ^ a[15:8];
  endfunction : mv

  // Pages close with their CRC
  task automatic rd(input logic [15:0] a, input logic [7:0] n, input logic ok);
    logic [15:0] c;
    logic [7:0]  e;
    c = crc(crc(crc(16'h0000, CMD_READ), a[7:0]), a[15:8]);
    exq = {};
    run(CMD_READ, a, 8'h00, ok ? read_pw : 64'h0, n);
    while (exq.size() < n)
    begin
      e = (!ok || a > MEM_LAST_ADDR) ? 8'hFF : mv(a);
      exq.push_back(e);
      if (ok && a <= MEM_LAST_ADDR)
      begin
        c = crc(c, e);
        a++;
        if (a[4:0] == 5'h00)
        begin
          exq.push_back(~c[7:0]);
          exq.push_back(~c[15:8]);
          c = 16'h0000;
        end
      end
    end
    for (int k = 0; k < n; k++)
      chk(rxq[k], exq[k]);
  endtask : rd

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    rd(16'h001E, 8'h24, 1'b1);
    rd(PW_FIRST - 16'h0004, 8'h26, 1'b1);
    rd(RSV_LAST - 16'h0001, 8'h04, 1'b1);
    rd(MEM_LAST_ADDR - 16'h0001, 8'h06, 1'b1);
    pw_enabled = 1'b1;
    rd(16'h0000, 8'h02, 1'b0);
    run(CMD_COPY, 16'h0040, 8'h1F, full_pw, 8'h01);
    chk(rxq[0], 8'h55);
    chk(nwe, 32);
    chk(ending_status, 8'h9F);
    pulse(4);
    chk(acc, 1'b0);
    run(CMD_COPY, 16'h0040, 8'h00, full_pw, 8'h01);
    chk({acc, rxq[0]}, 9'h0FF);
    run(CMD_COPY, 16'h0040, 8'h1F, read_pw, 8'h01);
    chk({acc, rxq[0]}, 9'h0FF);
    run(CMD_CLEAR, '0, '0, full_pw, '0);
    chk(memory_cleared_flag, 1'b1);
    run(CMD_START, '0, '0, full_pw, '0);
    chk({mission_active_flag, memory_cleared_flag}, 2'b10);
    run(CMD_CLEAR, '0, '0, full_pw, '0);
    chk(memory_cleared_flag, 1'b0);
    target_address = REG_FIRST;
    run(CMD_COPY, REG_FIRST, 8'h1F, full_pw, 8'h01);
    chk(acc, 1'b0);
    pulse(3);
    chk(awaiting_temp_alarm_flag, 1'b1);
    pulse(2);
    pulse(1);
    chk({nlog, nts}, {32'd1, 32'd1});
    pulse(0);
    run(CMD_CONV, '0, '0, '0, '0);
    repeat (30) @(negedge clk);
    chk(latest_temp, sensor_temp);
    start_on_temp_alarm = 1'b0;
    run(CMD_CLEAR, '0, '0, full_pw, '0);
    run(CMD_START, '0, '0, full_pw, '0);
    pulse(3);
    chk(sample_enable, 1'b1);
    stop_test();
  end
endmodule : datalogger_memory_command_unit_tb
